// >>> logic/dmac_defs.vh
/*
 * Constants for the signal-processing multiply/accumulate datapath:
 * widths, bit positions, operation codes and the word layout of the
 * control, status and interrupt words.
 * Assumes it is included by its bare name from the datapath module only.
 */
`ifndef DMAC_DEFS_VH
`define DMAC_DEFS_VH

// Datapath widths
`define DMAC_OPND_W      16
`define DMAC_MULIN_W     17
`define DMAC_PROD_W      33
`define DMAC_ACC_W       40
`define DMAC_ACC_MSB     39
`define DMAC_GUARD_LSB   32
`define DMAC_LOW_MSB     31
`define DMAC_SHIFT_W     6

// Accumulator operation codes
`define DMAC_OP_NONE     3'h0
`define DMAC_OP_MAC      3'h1
`define DMAC_OP_MSC      3'h2
`define DMAC_OP_ADD      3'h3
`define DMAC_OP_SUB      3'h4
`define DMAC_OP_LOAD     3'h5
`define DMAC_OP_CLR      3'h6

// Control word bits
`define DMAC_CTL_CLIP_B  7
`define DMAC_CTL_CLIP_A  6
`define DMAC_CTL_RANGE   4
`define DMAC_CTL_FRAC    0

// Trap enable bits
`define DMAC_TE_FIRST    0
`define DMAC_TE_SECOND   1

// Status word bits
`define DMAC_ST_OA       0
`define DMAC_ST_OB       1
`define DMAC_ST_SA       2
`define DMAC_ST_SB       3
`define DMAC_ST_OAB      4
`define DMAC_ST_SAB      5
`define DMAC_ST_W        6

// Register port offsets and reset values
`define DMAC_ADR_W       3
`define DMAC_REG_CTL     3'h0
`define DMAC_REG_STAT    3'h1
`define DMAC_REG_MASK    3'h2
`define DMAC_REG_TRAPEN  3'h3
`define DMAC_REG_IRQST   3'h4
`define DMAC_CTL_RST     8'h00
`define DMAC_MASK_RST    8'h00
`define DMAC_IRQ_W       4
`define DMAC_IRQ_OA      0
`define DMAC_IRQ_OB      1
`define DMAC_IRQ_SA      2
`define DMAC_IRQ_SB      3

`endif

// >>> logic/dmac_datapath.v
/*
 * Multiply/accumulate datapath of a 16-bit controller core: a 17x17
 * multiplier with fractional or integer scaler, a general product path,
 * a 40-bit adder/subtracter with two accumulators, pre-accumulation
 * shifter, guard-bit overflow detection, clipping and sticky clip status.
 * Assumes the instruction decoder drives operands and strobes
 * synchronously on clk, and software uses the small register port.
 */
`timescale 1ns/1ps
`include "dmac_defs.vh"

// Behaviour
// - Multiplier inputs are 17 bits; unsigned zero-extended, signed sign-extended.
// - Product is 33 bits, sign-extended to 40 before accumulation.
// - Scaler picks 1.31 fractional or plain 33-bit integer product.
// - Fractional mode treats operands as Q15, yielding a 1.31 product.
// - Integer multiplies support signed, unsigned and mixed-sign operands.
// - General product: bytes give 16-bit result, words give 32-bit result.
// - 40-bit adder/subtracter; one accumulator chosen as source and destination.
// - Add and load data may pass through the barrel shifter first.
// - One adder side can be zero; subtract complements with active-low borrow.
// - Overflow out of bit 39 is catastrophic; feeds clipping and flags.
// - Guard overflow flagged whenever bits 32 to 39 differ.
// - Overflow and clip indications latch into per-accumulator status flags.
// - Clipping uses adder result, overflows, per-accumulator enables, range select.
// - Clipped flag set on bit-31 clip, or guard overflow then bit-39 clip.
// - Combined flags are OR of both guard flags and both clipped flags.
// - Guard flag updated each adder operation, reflects latest operation.
// - Guard flag with matching trap enable raises an arithmetic warning trap.
module dmac_datapath #(
   parameter OPND_W = `DMAC_OPND_W
) (
   // Clock and reset
   input  wire                    clk,
   input  wire                    reset_n,
   // Multiply/accumulate request
   input  wire                    op_valid,
   input  wire [2:0]              op_code,
   input  wire                    acc_sel,
   input  wire [OPND_W-1:0]       opnd_x,
   input  wire [OPND_W-1:0]       opnd_y,
   input  wire                    x_signed,
   input  wire                    y_signed,
   input  wire [39:0]             add_data,
   input  wire                    shift_en,
   input  wire [5:0]              shift_amt,
   // General product request
   input  wire                    product_instr,
   input  wire                    product_byte,
   // Register port
   input  wire [2:0]              reg_addr,
   input  wire [7:0]              reg_wdata,
   input  wire                    reg_write,
   input  wire                    reg_read,
   output reg  [7:0]              reg_rdata,
   // Results
   output reg  [39:0]             first_accumulator,
   output reg  [39:0]             second_accumulator,
   output reg  [31:0]             product_result,
   output reg                     product_done,
   output reg  [5:0]              status_flags,
   output reg                     arith_warning_trap,
   output reg                     irq
);

   // Control state
   reg  [7:0]  core_control_reg;
   reg  [1:0]  interrupt_control_one;
   reg  [3:0]  irq_status;
   reg  [3:0]  irq_mask;
   reg         guard_overflow_first_acc;
   reg         guard_overflow_second_acc;
   reg         clipped_flag_first_acc;
   reg         clipped_flag_second_acc;

   wire clip_enable_first_acc  = core_control_reg[`DMAC_CTL_CLIP_A];
   wire clip_enable_second_acc = core_control_reg[`DMAC_CTL_CLIP_B];
   wire clip_range_select      = core_control_reg[`DMAC_CTL_RANGE];
   wire frac_mode              = core_control_reg[`DMAC_CTL_FRAC];

   // Extend a 16-bit operand into the 17th multiplier bit
   function [16:0] ext17;
      input [15:0] v;
      input        sgn;
      begin
         ext17 = {sgn & v[15], v};
      end
   endfunction

   // Signed 17x17 multiply into a 33-bit value
   function [32:0] mul17;
      input [16:0] a;
      input [16:0] b;
      reg   [33:0] p;
      begin
         p     = $signed(a) * $signed(b);
         mul17 = p[32:0];
      end
   endfunction

   // Multiplier and scaler
   wire [16:0] mul_x    = ext17(opnd_x, x_signed);
   wire [16:0] mul_y    = ext17(opnd_y, y_signed);
   wire [32:0] raw_prod = mul17(mul_x, mul_y);
   // Fractional shifts left one to place the binary point after the sign
   wire [32:0] scaled   = frac_mode ? {raw_prod[31:0], 1'b0} : raw_prod;
   wire [39:0] prod40   = {{7{scaled[32]}}, scaled};

   // Byte operands use the low bytes, sign-extended per operand
   wire [16:0] byte_x   = {{9{x_signed & opnd_x[7]}}, opnd_x[7:0]};
   wire [16:0] byte_y   = {{9{y_signed & opnd_y[7]}}, opnd_y[7:0]};
   wire [32:0] byte_p   = mul17(byte_x, byte_y);

   // True when a slice of the sum is not a pure copy of its sign
   function not_uniform;
      input [8:0] v;
      begin
         not_uniform = ~((&v) | ~(|v));
      end
   endfunction

   // Barrel shift of incoming data, signed amount: positive shifts right.
   // Each direction has its own net: inside one conditional the unsigned
   // left branch would turn the arithmetic right shift into a logical one
   // and lose the sign of negative data.
   wire [39:0] shr_val  = $signed(add_data) >>> shift_amt;
   wire [39:0] shl_val  = add_data << (~shift_amt + 6'h01);
   wire [39:0] shifted  = shift_amt[5] ? shl_val : shr_val;
   wire [39:0] data_in  = shift_en ? shifted : add_data;

   // Adder operand selection
   wire        is_sub   = (op_code == `DMAC_OP_MSC) || (op_code == `DMAC_OP_SUB);
   wire        zero_acc = (op_code == `DMAC_OP_LOAD) || (op_code == `DMAC_OP_CLR);
   wire [39:0] acc_cur  = acc_sel ? second_accumulator : first_accumulator;
   wire [39:0] add_a    = zero_acc ? 40'h00_0000_0000 : acc_cur;
   wire [39:0] b_src    = (op_code == `DMAC_OP_MAC || op_code == `DMAC_OP_MSC) ? prod40 :
                          (op_code == `DMAC_OP_CLR) ? 40'h00_0000_0000 : data_in;
   // Subtract: complement, borrow-in low means carry one
   wire [39:0] add_b    = is_sub ? ~b_src : b_src;
   wire        carry_in = is_sub ? 1'b1 : 1'b0;
   wire [40:0] sum      = {1'b0, add_a} + {1'b0, add_b} + {40'h00_0000_0000, carry_in};
   wire [39:0] res      = sum[39:0];

   // Overflow out of bit 39: operand signs agree, result sign differs
   wire ovf39 = (add_a[39] == add_b[39]) && (res[39] != add_a[39]);
   // Guard bits 32..39 not all equal; bit 31 takes no part here
   wire guard_ovf = not_uniform({res[39], res[39:32]});
   // Bit-31 overflow: the low 32-bit word no longer holds the sign
   wire ovf31     = not_uniform(res[39:31]);
   wire true_neg  = ovf39 ? add_a[39] : res[39];

   // Clipping decision and value
   wire clip_en   = acc_sel ? clip_enable_second_acc : clip_enable_first_acc;
   wire clip31    = clip_en & clip_range_select & (ovf31 | ovf39);
   wire clip39    = clip_en & ~clip_range_select & ovf39;
   wire do_clip   = clip31 | clip39;
   wire [39:0] clip_val = clip_range_select ?
                          (true_neg ? 40'hFF_8000_0000 : 40'h00_7FFF_FFFF) :
                          (true_neg ? 40'h80_0000_0000 : 40'h7F_FFFF_FFFF);
   wire [39:0] next_acc = do_clip ? clip_val : res;
   wire        acc_op   = op_valid && (op_code != `DMAC_OP_NONE);

   // Accumulators, guard flags and sticky clipped flags
   always @(posedge clk) begin
      if (!reset_n) begin
         first_accumulator         <= 40'h00_0000_0000;
         second_accumulator        <= 40'h00_0000_0000;
         guard_overflow_first_acc  <= 1'b0;
         guard_overflow_second_acc <= 1'b0;
         clipped_flag_first_acc    <= 1'b0;
         clipped_flag_second_acc   <= 1'b0;
      end else if (acc_op) begin
         if (acc_sel) begin
            second_accumulator        <= next_acc;
            guard_overflow_second_acc <= guard_ovf | ovf39;
            if (do_clip)
               clipped_flag_second_acc <= 1'b1;
         end else begin
            first_accumulator         <= next_acc;
            guard_overflow_first_acc  <= guard_ovf | ovf39;
            if (do_clip)
               clipped_flag_first_acc  <= 1'b1;
         end
      end
   end

   // Status word, combined flags and trap
   always @(posedge clk) begin
      if (!reset_n) begin
         status_flags       <= 6'h00;
         arith_warning_trap <= 1'b0;
      end else begin
         status_flags <= {clipped_flag_first_acc | clipped_flag_second_acc,
                          guard_overflow_first_acc | guard_overflow_second_acc,
                          clipped_flag_second_acc, clipped_flag_first_acc,
                          guard_overflow_second_acc, guard_overflow_first_acc};
         arith_warning_trap <=
            (guard_overflow_first_acc & interrupt_control_one[`DMAC_TE_FIRST]) |
            (guard_overflow_second_acc & interrupt_control_one[`DMAC_TE_SECOND]);
      end
   end

   // General product path, one-cycle result
   always @(posedge clk) begin
      if (!reset_n) begin
         product_result <= 32'h0000_0000;
         product_done   <= 1'b0;
      end else begin
         product_done <= product_instr;
         if (product_instr)
            product_result <= product_byte ? {16'h0000, byte_p[15:0]} : raw_prod[31:0];
      end
   end

   // Interrupt events: guard overflow and clip on each accumulator
   wire [3:0] irq_event = {acc_op & acc_sel & do_clip, acc_op & ~acc_sel & do_clip,
                           acc_op & acc_sel & (guard_ovf | ovf39),
                           acc_op & ~acc_sel & (guard_ovf | ovf39)};
   wire wr_irqst = reg_write && (reg_addr == `DMAC_REG_IRQST);

   // Registers; event set wins over write-one clear
   always @(posedge clk) begin
      if (!reset_n) begin
         core_control_reg      <= `DMAC_CTL_RST;
         interrupt_control_one <= 2'h0;
         irq_mask              <= 4'h0;
         irq_status            <= 4'h0;
         reg_rdata             <= 8'h00;
         irq                   <= 1'b0;
      end else begin
         if (reg_write && reg_addr == `DMAC_REG_CTL)
            core_control_reg <= reg_wdata;
         if (reg_write && reg_addr == `DMAC_REG_TRAPEN)
            interrupt_control_one <= reg_wdata[1:0];
         if (reg_write && reg_addr == `DMAC_REG_MASK)
            irq_mask <= reg_wdata[3:0];
         irq_status <= (irq_status & ~(wr_irqst ? reg_wdata[3:0] : 4'h0)) | irq_event;
         irq        <= |(irq_status & irq_mask);
         if (reg_read) begin
            case (reg_addr)
               `DMAC_REG_CTL:    reg_rdata <= core_control_reg;
               `DMAC_REG_STAT:   reg_rdata <= {2'h0, status_flags};
               `DMAC_REG_MASK:   reg_rdata <= {4'h0, irq_mask};
               `DMAC_REG_TRAPEN: reg_rdata <= {6'h00, interrupt_control_one};
               `DMAC_REG_IRQST:  reg_rdata <= {4'h0, irq_status};
               default:          reg_rdata <= 8'h00;
            endcase
         end else begin
            reg_rdata <= 8'h00;
         end
      end
   end

endmodule

// >>> verif/dmac_props.sv
/* Checker on the ports of the multiply/accumulate datapath.
   Assumes a bind from the bench top; one clock, sync reset. */
`timescale 1ns/1ps
module dmac_props (
   // Clock and reset
   input wire logic        clk,
   input wire logic        reset_n,
   // Requests
   input wire logic        op_valid,
   input wire logic [2:0]  op_code,
   input wire logic        acc_sel,
   input wire logic [39:0] add_data,
   input wire logic        shift_en,
   input wire logic        product_instr,
   // Results
   input wire logic [39:0] first_accumulator,
   input wire logic [5:0]  status_flags,
   input wire logic        product_done
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   // Adder operation on the first accumulator
   sequence s_op_a;
      op_valid && !acc_sel && op_code inside {[3'h1:3'h5]};
   endsequence
   // Guard bits disagree
   sequence s_guard_a;
      first_accumulator[39:32] != 8'h00 && first_accumulator[39:32] != 8'hFF;
   endsequence
   AST_OAB: assert property (status_flags[4] == (status_flags[0] | status_flags[1]))
      else $error("combined guard flag wrong");
   AST_SAB: assert property (status_flags[5] == (status_flags[2] | status_flags[3]))
      else $error("combined clipped flag wrong");
   AST_GUARD: assert property (s_op_a ##1 s_guard_a |=> status_flags[0])
      else $error("guard overflow not flagged");
   AST_CLEAR: assert property (op_valid && !acc_sel && op_code == 3'h6
      |=> first_accumulator == 40'h0)
      else $error("clear left accumulator nonzero");
   // Values without guard content load unchanged in every clip mode
   AST_LOAD: assert property (op_valid && !acc_sel && op_code == 3'h5 && !shift_en
      && (add_data[39:31] == 9'h000 || add_data[39:31] == 9'h1FF)
      |=> first_accumulator == $past(add_data))
      else $error("load value wrong");
   AST_HOLD: assert property (!(op_valid && !acc_sel && op_code inside {[3'h1:3'h6]})
      |=> $stable(first_accumulator))
      else $error("accumulator changed without operation");
   AST_PDONE: assert property (product_instr |=> product_done)
      else $error("product not done");
   AST_PQUIET: assert property (!product_instr |=> !product_done)
      else $error("spurious product done");
endmodule

// >>> verif/dmac_decoder_model.sv
/* Model of the instruction decoder feeding operands and strobes.
   Assumes the bench calls its tasks; strobes last one cycle. */
`timescale 1ns/1ps
module dmac_decoder_model (
   // Clock
   input wire logic  clk,
   // Accumulator request
   output logic        op_valid,
   output logic [2:0]  op_code,
   output logic        acc_sel,
   output logic [15:0] opnd_x,
   output logic [15:0] opnd_y,
   output logic        x_signed,
   output logic        y_signed,
   output logic [39:0] add_data,
   output logic        shift_en,
   output logic [5:0]  shift_amt,
   // General product request
   output logic        product_instr,
   output logic        product_byte
);
   initial {op_valid, op_code, acc_sel, opnd_x, opnd_y, x_signed, y_signed, add_data,
      shift_en, shift_amt, product_instr, product_byte} = '0;
   // Released operands turn over so stale values never match by luck
   task issue(input [2:0] c, input s, input [39:0] d, input [15:0] x, y,
              input xs, ys, se, input [5:0] sa);
      @(posedge clk);
      {op_valid, op_code, acc_sel, add_data} <= {1'b1, c, s, d};
      {opnd_x, opnd_y, x_signed, y_signed, shift_en, shift_amt} <= {x, y, xs, ys, se, sa};
      @(posedge clk);
      {op_valid, add_data, opnd_x, opnd_y} <= {1'b0, ~d, ~x, ~y};
      #1;
   endtask
   task prod(input [15:0] x, y, input xs, ys, b);
      @(posedge clk);
      {product_instr, opnd_x, opnd_y, x_signed, y_signed, product_byte} <= {1'b1, x, y, xs, ys, b};
      @(posedge clk);
      {product_instr, opnd_x, opnd_y} <= {1'b0, ~x, ~y};
      #1;
   endtask
endmodule

// >>> verif/dsp_mac_datapath_test.sv
/* Self-checking bench of the multiply/accumulate datapath.
   Assumes the decoder model drives requests; registers via a plain port. */
`timescale 1ns/1ps
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin err_count++; \
   $display("unexpected %s exp %h got %h", n, e, a); end end
module dsp_mac_datapath_test;
   logic clk = 0, reset_n = 0, reg_write = 0, reg_read = 0, irq_a;
   logic [2:0] reg_addr = 3'h0, c;
   logic [7:0] reg_wdata = 8'h00, r;
   wire  [7:0] reg_rdata;
   wire  [39:0] acc_a, acc_b;
   wire  [31:0] product_result;
   wire  [5:0] status_flags;
   wire  product_done, trap, irq;
   int   err_count = 0, comparisons = 0, cyc = 0, i;
   logic [31:0] rs = 32'h000178E5;
   logic [39:0] am [2] = '{40'h0, 40'h0};
   logic [39:0] p, d;
   logic s, xs, ys;
   dmac_decoder_model dec (.clk(clk), .op_valid(), .op_code(), .acc_sel(), .opnd_x(), .opnd_y(),
      .x_signed(), .y_signed(), .add_data(), .shift_en(), .shift_amt(), .product_instr(),
      .product_byte());
   dmac_datapath dut (.clk(clk), .reset_n(reset_n), .op_valid(dec.op_valid),
      .op_code(dec.op_code), .acc_sel(dec.acc_sel), .opnd_x(dec.opnd_x), .opnd_y(dec.opnd_y),
      .x_signed(dec.x_signed), .y_signed(dec.y_signed), .add_data(dec.add_data),
      .shift_en(dec.shift_en), .shift_amt(dec.shift_amt), .product_instr(dec.product_instr),
      .product_byte(dec.product_byte), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
      .first_accumulator(acc_a), .second_accumulator(acc_b), .product_result(product_result),
      .product_done(product_done), .status_flags(status_flags), .arith_warning_trap(trap),
      .irq(irq));
   always #12.5 clk = ~clk;
   // Random source, fixed start
   function [31:0] nxt(input [31:0] v);
      nxt = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   // Operands widened to 17 bits by their sign mode, scaled in fractional mode
   function [39:0] mulx(input [15:0] x, y, input xs, ys, fr);
      logic signed [16:0] a, b;
      logic signed [39:0] q;
      a = {xs & x[15], x};
      b = {ys & y[15], y};
      q = a * b;
      mulx = fr ? {{7{q[31]}}, q[31:0], 1'b0} : q;
   endfunction
   task wr(input [2:0] a, input [7:0] v);
      @(posedge clk);
      {reg_write, reg_addr, reg_wdata} <= {1'b1, a, v};
      @(posedge clk);
      reg_write <= 1'b0;
   endtask
   task rd(input [2:0] a, output [7:0] v);
      @(posedge clk);
      {reg_read, reg_addr} <= {1'b1, a};
      @(posedge clk);
      reg_read <= 1'b0;
      #1 v = reg_rdata;
   endtask
   task print_verdict;
      $display("mismatches %0d, comparisons %0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // Hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count++;
         print_verdict;
      end
   end
   initial begin
      repeat (16) @(posedge clk);
      reset_n <= 1'b1;
      #1 `CHK("status", 6'h00, status_flags)
      rd(3'h7, r); `CHK("unmapped", 8'h00, r)
      // Shifter on load and add, right then left
      dec.issue(3'h5, 0, 40'h0000001230, 0, 0, 0, 0, 1, 6'h04);
      `CHK("shr", 40'h0000000123, acc_a)
      dec.issue(3'h5, 0, 40'h0000001230, 0, 0, 0, 0, 1, 6'h3E);
      `CHK("shl", 40'h00000048C0, acc_a)
      dec.issue(3'h3, 0, 40'hFFFFFFFF00, 0, 0, 0, 0, 1, 6'h04);
      `CHK("shadd", 40'h00000048B0, acc_a)
      dec.issue(3'h6, 0, 40'h1, 0, 0, 0, 0, 0, 6'h00);
      `CHK("clear", 40'h0, acc_a)
      // Random multiply/accumulate, integer then fractional
      for (i = 0; i < 48; i++) begin
         if (i % 24 == 0) wr(3'h0, {7'h00, i[5]^i[4]});
         rs = nxt(rs);
         c = 3'h1 + rs[2:0] % 5;
         s = rs[3];
         rs = nxt(rs);
         {xs, ys} = rs[17:16];
         d = {{8{rs[31]}}, rs};
         p = mulx(rs[31:16], rs[15:0], xs, ys, i >= 24);
         am[s] = c == 3'h1 ? am[s] + p : c == 3'h2 ? am[s] - p :
                 c == 3'h3 ? am[s] + d : c == 3'h4 ? am[s] - d : d;
         dec.issue(c, s, d, rs[31:16], rs[15:0], xs, ys, 0, 6'h00);
         `CHK("acc", am[s], s ? acc_b : acc_a)
      end
      // Guard overflow, trap and interrupt
      wr(3'h0, 8'h00);
      wr(3'h3, 8'h01);
      dec.issue(3'h5, 0, 40'h0100000000, 0, 0, 0, 0, 0, 6'h00);
      @(posedge clk) #1 `CHK("oa", 1'b1, status_flags[0])
      `CHK("oab", 1'b1, status_flags[4])
      `CHK("trap", 1'b1, trap)
      rd(3'h4, r); `CHK("irqst", 1'b1, r[0])
      wr(3'h2, 8'h0F); #1 irq_a = irq;
      wr(3'h2, 8'h00); #1 `CHK("mask", 1'b1, irq_a ^ irq)
      dec.issue(3'h5, 0, 40'h10, 0, 0, 0, 0, 0, 6'h00);
      @(posedge clk) #1 `CHK("oa clr", 1'b0, status_flags[0])
      wr(3'h4, 8'hFF); rd(3'h4, r); `CHK("w1c", 8'h00, r)
      // Clipping, 32-bit range both signs then 40-bit range
      wr(3'h0, 8'h50);
      dec.issue(3'h5, 0, 40'h007FFFFFF0, 0, 0, 0, 0, 0, 6'h00);
      dec.issue(3'h3, 0, 40'h20, 0, 0, 0, 0, 0, 6'h00);
      `CHK("clip pos", 40'h007FFFFFFF, acc_a)
      @(posedge clk) #1 `CHK("sa", 1'b1, status_flags[2])
      `CHK("sab", 1'b1, status_flags[5])
      dec.issue(3'h4, 0, 40'h0100000000, 0, 0, 0, 0, 0, 6'h00);
      `CHK("clip neg", 40'hFF80000000, acc_a)
      wr(3'h0, 8'h80);
      dec.issue(3'h5, 1, 40'h7FFFFFFFF0, 0, 0, 0, 0, 0, 6'h00);
      dec.issue(3'h3, 1, 40'h20, 0, 0, 0, 0, 0, 6'h00);
      `CHK("clip 39", 40'h7FFFFFFFFF, acc_b)
      @(posedge clk) #1 `CHK("sb", 1'b1, status_flags[3])
      `CHK("ob", 1'b1, status_flags[1])
      // General product, all sign mixes, then bytes
      for (i = 0; i < 4; i++) begin
         rs = nxt(rs);
         p = mulx(rs[31:16], rs[15:0], i[0], i[1], 0);
         dec.prod(rs[31:16], rs[15:0], i[0], i[1], 0);
         `CHK("word", p[31:0], product_result)
      end
      dec.prod(16'h12FE, 16'h34FD, 0, 0, 1);
      `CHK("byte", 32'h0000FB06, product_result)
      print_verdict;
   end
endmodule
bind dmac_datapath dmac_props chk (.clk(clk), .reset_n(reset_n), .op_valid(op_valid),
   .op_code(op_code), .acc_sel(acc_sel), .add_data(add_data), .shift_en(shift_en),
   .product_instr(product_instr), .first_accumulator(first_accumulator),
   .status_flags(status_flags), .product_done(product_done));
